// >>> stc_pkg.sv
/*
  Package for the special-mode test control block: register byte offsets,
  field positions, reset values, the packed carrier of the test control
  fields, and the bus constants. Assumes a 32-bit AHB-Lite register bus.
*/
package stc_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_TEST_CTRL = 8'h00; // test_functions_control
  localparam logic [7:0] OFS_BAUD_TEST = 8'h04; // serial_baud_rate_control test bits
  localparam logic [7:0] OFS_MODE = 8'h08;      // mode privileges
  localparam logic [7:0] OFS_STATUS = 8'h0c;    // read-only status

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int TC_ILLEGAL_OP = 7;
  localparam int TC_CC_OUT = 6;
  localparam int TC_BYPASS = 5;
  localparam int TC_RST_DIS = 4;
  localparam int TC_FORCE_CM = 3;
  localparam int TC_FORCE_WD = 2;
  localparam int TC_CFG_OVR = 1;
  localparam int BT_CHAIN_CLR = 7;
  localparam int BT_CLK_TEST = 6;
  localparam int MD_SPECIAL = 0;
  localparam int MD_IRV = 1;
  localparam int MD_MUX_BUS = 2;
  localparam int MD_BOOT_ROM = 3;

  // ------------------------------------------------------------
  // reset values and fixed addresses
  // ------------------------------------------------------------
  localparam logic [7:0] TEST_CTRL_RESET = 8'h00;
  localparam logic [15:0] VECTOR_BASE_SPECIAL = 16'hbfc0;
  localparam logic [15:0] VECTOR_BASE_NORMAL = 16'hffc0;
  localparam logic [15:0] BOOT_ROM_BASE = 16'hbf40;
  localparam logic [15:0] BOOT_ROM_LAST = 16'hbfff;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  // ------------------------------------------------------------
  // carrier of the test control fields
  // ------------------------------------------------------------
  typedef struct packed {
    logic illegal_opcode_test_enable;
    logic condition_code_output_enable;
    logic timer_divider_bypass;
    logic reset_disable;
    logic force_clock_monitor_failure;
    logic force_watchdog_timeout;
    logic configuration_override;
    logic spare;
  } test_ctrl_t;

endpackage

// >>> special_mode_test_control.sv
/*
  Special-mode test control block: test control register, baud test bits,
  mode privilege latch and the datapath effects they steer.
  Assumes one 10 MHz clock, an AHB-Lite master, CPU/timer/SCI signals on
  the same clock, and the instruction-fetch indicator arriving from a pin.
*/
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
// Overview of operation
// - test control writable only in special mode
// - normal mode: test control zero, writes refused
// - special latch set at reset, clear-only
// - illegal opcode test: no service, address decrements
// - condition code flags drive port A 7..3
// - condition code output removes internal ROM
// - bypass splits timer, E clock drives halves
// - reset disable blocks resets; zero in normal
// - reset disable is one after special reset
// - forced clock monitor failure needs monitor enable
// - forced watchdog timeout needs watchdog enabled
// - reset disable beats both forced failures
// - override maps ROM, EEPROM, enables watchdog
// - baud test bits special only, cleared normal
// - baud test bits always read zero
// - chain clear write resets baud chain
// - clock test puts rx xor tx clock
// - watchdog, clock monitor off by default special
// - opcode zero makes address a counter
// - visibility drives internal reads onto bus
// - visibility disabled in normal modes
// - bootstrap reset maps boot ROM for vectors
// - boot firmware loads program, jumps zero
// - bootstrap lets software enable multiplexed bus
// - clearing boot ROM enable unmaps it
`timescale 1ns/1ns
module special_mode_test_control
  import stc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // mode straps from the reset logic, steady around reset release
  input wire logic special_mode_strap_i,
  input wire logic bootstrap_strap_i,
  input wire logic expanded_strap_i,
  // configuration sources
  input wire logic clock_monitor_enable_i,
  input wire logic watchdog_disable_config_i,
  input wire logic rom_enable_config_i,
  input wire logic watchdog_timeout_i,
  input wire logic clock_fail_i,
  // CPU side
  input wire logic [4:0] cc_flags_i,
  input wire logic [4:0] port_a_normal_i,
  input wire logic instruction_fetch_indicator_b_i,
  input wire logic illegal_opcode_i,
  input wire logic opcode_zero_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic internal_read_i,
  input wire logic [7:0] internal_data_i,
  // SCI side
  input wire logic rx_clk_i,
  input wire logic tx_clk_i,
  input wire logic txd_i,
  // outputs
  output logic [4:0] port_a_o,
  output logic watchdog_reset_o,
  output logic clock_monitor_reset_o,
  output logic watchdog_active_o,
  output logic clock_monitor_active_o,
  output logic rom_mapped_o,
  output logic eeprom_mapped_o,
  output logic boot_rom_mapped_o,
  output logic [15:0] vector_base_o,
  output logic timer_split_o,
  output logic baud_chain_reset_o,
  output logic transmit_data_pin_o,
  output logic [7:0] ext_data_o,
  output logic ext_data_oe_b_o,
  output logic multiplexed_bus_o,
  output logic [15:0] addr_o,
  output logic addr_override_o,
  output logic illegal_no_service_o
);

  // ------------------------------------------------------------
  // reset release and strap capture
  // ------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;
  logic straps_taken;
  logic expanded;

  // two flops so the release is clean against the clock
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // straps cannot be loaded under the async reset, so they are taken
  // on the first edge after release
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      straps_taken <= 1'b0;
    else
      straps_taken <= 1'b1;
  end

  // ------------------------------------------------------------
  // AHB-Lite address and data phase
  // ------------------------------------------------------------
  logic wr_pend;
  logic [7:0] wr_addr;
  logic rd_go;
  logic wr_go;
  logic [7:0] wdata;

  assign rd_go = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ) && !hwrite_i;
  assign wdata = hwdata_i[7:0];
  assign wr_go = wr_pend;

  // write address is held into the data phase, where hwdata stands
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ) && hwrite_i;
      wr_addr <= haddr_i;
    end
  end

  // zero wait states, always OKAY
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hreadyout_o <= 1'b0;
      hresp_o <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // mode privileges
  // ------------------------------------------------------------
  logic special_mode_latch;
  logic internal_read_visibility;
  logic multiplexed_bus_enable;
  logic boot_rom_enable;
  logic mode_wr;

  assign mode_wr = wr_go && (wr_addr == OFS_MODE);

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      special_mode_latch <= 1'b0;
      internal_read_visibility <= 1'b0;
      multiplexed_bus_enable <= 1'b0;
      boot_rom_enable <= 1'b0;
      expanded <= 1'b0;
    end
    else if (!straps_taken)
    begin
      special_mode_latch <= special_mode_strap_i;
      internal_read_visibility <= special_mode_strap_i && !bootstrap_strap_i;
      multiplexed_bus_enable <= expanded_strap_i;
      boot_rom_enable <= special_mode_strap_i && bootstrap_strap_i;
      expanded <= expanded_strap_i;
    end
    else if (mode_wr)
    begin
      // latch and visibility may be cleared, never set again
      special_mode_latch <= special_mode_latch && wdata[MD_SPECIAL];
      internal_read_visibility <= internal_read_visibility && wdata[MD_IRV]
        && wdata[MD_SPECIAL];
      if (special_mode_latch)
      begin
        multiplexed_bus_enable <= wdata[MD_MUX_BUS];
        boot_rom_enable <= wdata[MD_BOOT_ROM];
      end
    end
  end

  // ------------------------------------------------------------
  // test control and baud test bits
  // ------------------------------------------------------------
  test_ctrl_t test_ctrl;
  logic baud_clock_test;
  logic force_cm_pulse;
  logic force_wd_pulse;
  logic tc_wr;
  logic bt_wr;

  assign tc_wr = wr_go && (wr_addr == OFS_TEST_CTRL) && special_mode_latch;
  assign bt_wr = wr_go && (wr_addr == OFS_BAUD_TEST) && special_mode_latch;

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      test_ctrl <= test_ctrl_t'(TEST_CTRL_RESET);
    else if (!straps_taken)
    begin
      test_ctrl <= test_ctrl_t'(TEST_CTRL_RESET);
      test_ctrl.reset_disable <= special_mode_strap_i;
    end
    else if (!special_mode_latch)
      test_ctrl <= test_ctrl_t'(TEST_CTRL_RESET);
    else if (tc_wr)
    begin
      test_ctrl <= test_ctrl_t'(wdata);
      test_ctrl.spare <= 1'b0;
    end
  end

  // a write of one to a force bit fires once, at the write
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      force_cm_pulse <= 1'b0;
      force_wd_pulse <= 1'b0;
    end
    else
    begin
      force_cm_pulse <= tc_wr && wdata[TC_FORCE_CM];
      force_wd_pulse <= tc_wr && wdata[TC_FORCE_WD];
    end
  end

  // the test bits have no read path; they only steer the SCI pins
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      baud_clock_test <= 1'b0;
      baud_chain_reset_o <= 1'b0;
    end
    else
    begin
      if (!special_mode_latch)
        baud_clock_test <= 1'b0;
      else if (bt_wr)
        baud_clock_test <= wdata[BT_CLK_TEST];
      baud_chain_reset_o <= bt_wr && wdata[BT_CHAIN_CLR];
    end
  end

  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb
  begin
    next_rdata = 8'h00;
    unique case (haddr_i)
      OFS_TEST_CTRL: next_rdata = test_ctrl;
      OFS_BAUD_TEST: next_rdata = 8'h00;
      OFS_MODE: next_rdata = {4'h0, boot_rom_enable, multiplexed_bus_enable,
        internal_read_visibility, special_mode_latch};
      OFS_STATUS: next_rdata = {2'b00, addr_override_o, illegal_no_service_o,
        watchdog_active_o, clock_monitor_active_o, rom_mapped_o,
        boot_rom_mapped_o};
      default: next_rdata = 8'h00;
    endcase
  end

  // data is sampled in the address phase and stands in the data phase
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      hrdata_o <= 32'h0000_0000;
    else if (rd_go)
      hrdata_o <= {24'h00_0000, next_rdata};
  end

  // ------------------------------------------------------------
  // watchdog and clock monitor resets, memory map
  // ------------------------------------------------------------
  logic wd_enabled;
  logic cm_enabled;

  assign wd_enabled = !watchdog_disable_config_i || test_ctrl.configuration_override;
  assign cm_enabled = clock_monitor_enable_i;

  // reset disable dominates every source, forced ones included
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      watchdog_reset_o <= 1'b0;
      clock_monitor_reset_o <= 1'b0;
      watchdog_active_o <= 1'b0;
      clock_monitor_active_o <= 1'b0;
    end
    else
    begin
      watchdog_reset_o <= !test_ctrl.reset_disable && wd_enabled
        && (watchdog_timeout_i || force_wd_pulse);
      clock_monitor_reset_o <= !test_ctrl.reset_disable && cm_enabled
        && (clock_fail_i || force_cm_pulse);
      watchdog_active_o <= !test_ctrl.reset_disable && wd_enabled;
      clock_monitor_active_o <= !test_ctrl.reset_disable && cm_enabled;
    end
  end

  // normal single-chip forces ROM on so a reset vector exists
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rom_mapped_o <= 1'b0;
      eeprom_mapped_o <= 1'b0;
      boot_rom_mapped_o <= 1'b0;
      vector_base_o <= VECTOR_BASE_NORMAL;
      multiplexed_bus_o <= 1'b0;
      timer_split_o <= 1'b0;
    end
    else
    begin
      rom_mapped_o <= !test_ctrl.condition_code_output_enable
        && (rom_enable_config_i || test_ctrl.configuration_override
        || (!special_mode_latch && !expanded));
      eeprom_mapped_o <= 1'b1;
      boot_rom_mapped_o <= boot_rom_enable;
      vector_base_o <= special_mode_latch ? VECTOR_BASE_SPECIAL : VECTOR_BASE_NORMAL;
      multiplexed_bus_o <= multiplexed_bus_enable;
      timer_split_o <= test_ctrl.timer_divider_bypass;
    end
  end

  // ------------------------------------------------------------
  // port A, SCI pin and data bus visibility
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_a_o <= 5'h00;
      transmit_data_pin_o <= 1'b1;
      ext_data_o <= 8'h00;
      ext_data_oe_b_o <= 1'b1;
    end
    else
    begin
      // flags in order H N Z V C onto bits 7..3
      port_a_o <= test_ctrl.condition_code_output_enable ? cc_flags_i
        : port_a_normal_i;
      transmit_data_pin_o <= baud_clock_test ? (rx_clk_i ^ tx_clk_i) : txd_i;
      ext_data_o <= internal_data_i;
      ext_data_oe_b_o <= !(special_mode_latch && internal_read_visibility
        && internal_read_i);
    end
  end

  // ------------------------------------------------------------
  // address bus test sequences
  // ------------------------------------------------------------
  logic [2:0] lir_sync;
  logic lir_low;
  logic counting;
  logic decrementing;

  // pin input: three flops, change accepted when the last two agree
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lir_sync <= 3'b111;
      lir_low <= 1'b0;
    end
    else
    begin
      lir_sync <= {lir_sync[1:0], instruction_fetch_indicator_b_i};
      if (lir_sync[1] == lir_sync[2])
        lir_low <= !lir_sync[2];
    end
  end

  // the zero-opcode counter has no way out but reset
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      counting <= 1'b0;
      decrementing <= 1'b0;
      addr_o <= 16'h0000;
      addr_override_o <= 1'b0;
      illegal_no_service_o <= 1'b0;
    end
    else
    begin
      illegal_no_service_o <= test_ctrl.illegal_opcode_test_enable && lir_low;
      if (counting)
        addr_o <= addr_o + 16'h0001;
      else if (special_mode_latch && opcode_zero_i)
      begin
        counting <= 1'b1;
        addr_o <= cpu_addr_i + 16'h0001;
      end
      else if (decrementing)
      begin
        addr_o <= addr_o - 16'h0001;
        decrementing <= test_ctrl.illegal_opcode_test_enable && lir_low;
      end
      else if (test_ctrl.illegal_opcode_test_enable && lir_low && illegal_opcode_i)
      begin
        decrementing <= 1'b1;
        addr_o <= cpu_addr_i - 16'h0001;
      end
      addr_override_o <= counting || decrementing
        || (special_mode_latch && opcode_zero_i)
        || (test_ctrl.illegal_opcode_test_enable && lir_low && illegal_opcode_i);
    end
  end

endmodule

// >>> special_mode_test_control_monitor.sv
/*
  Checker for the special-mode test control block: port-level properties.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ns
module special_mode_test_control_monitor
  import stc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [4:0] cc_flags_i,
  input wire logic [4:0] port_a_normal_i,
  input wire logic [4:0] port_a_o,
  input wire logic clock_monitor_enable_i,
  input wire logic clock_monitor_reset_o,
  input wire logic baud_chain_reset_o,
  input wire logic rx_clk_i,
  input wire logic tx_clk_i,
  input wire logic txd_i,
  input wire logic transmit_data_pin_o,
  input wire logic internal_read_i,
  input wire logic [7:0] internal_data_i,
  input wire logic [7:0] ext_data_o,
  input wire logic ext_data_oe_b_o,
  input wire logic [15:0] vector_base_o,
  input wire logic opcode_zero_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic [15:0] addr_o,
  input wire logic addr_override_o,
  input wire logic illegal_no_service_o
);
  // ------------------------------------------------------------
  // one clock domain, checks paused while the pin reset is low
  // ------------------------------------------------------------
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  // counting starts on opcode zero while vectors show the special latch
  sequence zero_start_s;
    opcode_zero_i && vector_base_o == VECTOR_BASE_SPECIAL && !addr_override_o;
  endsequence
  sequence count_up_s;
    (addr_o == $past(addr_o) + 16'h1) [*3];
  endsequence

  // hreadyout is only trusted once it has been high for a cycle
  bus_okay_a: assert property ($past(hreadyout_o) |-> hreadyout_o && !hresp_o)
    else $error("bus stalled or not okay");
  port_a_cc_a: assert property ($past(hreadyout_o) && port_a_o != $past(port_a_normal_i)
    |-> port_a_o == $past(cc_flags_i))
    else $error("port a neither normal nor flags");
  monitor_enable_a: assert property (clock_monitor_reset_o |-> $past(clock_monitor_enable_i))
    else $error("monitor reset without enable");
  chain_pulse_a: assert property (baud_chain_reset_o |=> !baud_chain_reset_o)
    else $error("chain reset longer than one cycle");
  txd_pin_a: assert property ($past(hreadyout_o) && transmit_data_pin_o != $past(txd_i)
    |-> transmit_data_pin_o == ($past(rx_clk_i) ^ $past(tx_clk_i)))
    else $error("transmit pin neither data nor clock test");
  read_vis_a: assert property (!ext_data_oe_b_o
    |-> $past(internal_read_i) && ext_data_o == $past(internal_data_i))
    else $error("external bus driven without internal read");
  vis_normal_a: assert property (vector_base_o == VECTOR_BASE_NORMAL
    && $past(vector_base_o) == VECTOR_BASE_NORMAL |-> ext_data_oe_b_o)
    else $error("read visibility in normal mode");
  count_up_a: assert property (zero_start_s |=> addr_override_o
    && addr_o == $past(cpu_addr_i) + 16'h1 ##1 count_up_s)
    else $error("address counter not counting");
  // no-service alone is up while waiting for the first illegal opcode;
  // only with the override up is the address really being decremented
  count_down_a: assert property (illegal_no_service_o && addr_override_o
    |=> addr_o == $past(addr_o) - 16'h1)
    else $error("illegal test address not decrementing");
endmodule

// >>> special_mode_test_control_bench.sv
/*
  Self-checking bench for the special-mode test control block.
  Assumes the bench is the only AHB-Lite master and drives all block inputs.
*/
`timescale 1ns/1ns
module special_mode_test_control_bench;
  import stc_pkg::*;
  logic clk_sys_i, rst_b_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o;
  logic [7:0] haddr_i, internal_data_i, ext_data_o, rdat;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  logic [31:0] hwdata_i, hrdata_o;
  logic special_mode_strap_i, bootstrap_strap_i, expanded_strap_i;
  logic clock_monitor_enable_i, watchdog_disable_config_i, rom_enable_config_i;
  logic watchdog_timeout_i, clock_fail_i, instruction_fetch_indicator_b_i;
  logic [4:0] cc_flags_i, port_a_normal_i, port_a_o;
  logic illegal_opcode_i, opcode_zero_i, internal_read_i;
  logic [15:0] cpu_addr_i, vector_base_o, addr_o;
  logic rx_clk_i, tx_clk_i, txd_i, watchdog_reset_o, clock_monitor_reset_o;
  logic watchdog_active_o, clock_monitor_active_o, rom_mapped_o, eeprom_mapped_o;
  logic boot_rom_mapped_o, timer_split_o, baud_chain_reset_o, transmit_data_pin_o;
  logic ext_data_oe_b_o, multiplexed_bus_o, addr_override_o, illegal_no_service_o;
  int miscompares, num_checks, nw, nc, nb, cycles;

  special_mode_test_control i_special_mode_test_control (.*);
  // single slave, so its ready is the bus ready
  assign hready_i = hreadyout_o;

  // ------------------------------------------------------------
  // clock, hang guard and shared tasks
  // ------------------------------------------------------------
  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // the whole run needs under two hundred cycles; a hang ends here
  always @(posedge clk_sys_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      final_report();
    end
  end

  task automatic final_report;
    if (miscompares == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // step past edges, then 1 ns so registered outputs have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // one word transfer; the read byte is left in rdat
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel_i <= 1'b1;
    htrans_i <= HTRANS_NONSEQ;
    haddr_i <= a;
    hwrite_i <= w;
    @(posedge clk_sys_i);
    while (hready_i !== 1'b1) @(posedge clk_sys_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= {24'h0, d};
    @(posedge clk_sys_i);
    while (hready_i !== 1'b1) @(posedge clk_sys_i);
    rdat = hrdata_o[7:0];
    #1;
  endtask

  // straps are held steady across the release
  task automatic boot(input logic sp, input logic bs);
    rst_b_i <= 1'b0;
    special_mode_strap_i <= sp;
    bootstrap_strap_i <= bs;
    cyc(4);
    rst_b_i <= 1'b1;
    cyc(6);
  endtask

  // count pulse cycles; sample first so a pulse already up is seen
  task automatic watch(input int n);
    nw = 0;
    nc = 0;
    nb = 0;
    repeat (n)
    begin
      nw += int'(watchdog_reset_o);
      nc += int'(clock_monitor_reset_o);
      nb += int'(baud_chain_reset_o);
      cyc(1);
    end
  endtask

  task automatic fw(input logic [7:0] d, input int ew, input int ec);
    xfer(1'b1, OFS_TEST_CTRL, d);
    watch(4);
    chk("watchdog reset", 16'(ew), 16'(nw));
    chk("monitor reset", 16'(ec), 16'(nc));
  endtask

  task automatic hit(input int ew, input int ec);
    watchdog_timeout_i <= 1'b1;
    clock_fail_i <= 1'b1;
    cyc(1);
    watchdog_timeout_i <= 1'b0;
    clock_fail_i <= 1'b0;
    watch(4);
    chk("watchdog reset", 16'(ew), 16'(nw));
    chk("monitor reset", 16'(ec), 16'(nc));
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_normal;
    boot(1'b0, 1'b0);
    xfer(1'b1, OFS_TEST_CTRL, 8'hfe);
    xfer(1'b0, OFS_TEST_CTRL, 8'h00);
    chk("test ctrl", 16'h0, 16'(rdat));
    xfer(1'b0, 8'h20, 8'h00);
    chk("unmapped", 16'h0, 16'(rdat));
    xfer(1'b0, OFS_STATUS, 8'h00);
    chk("status", 16'h0e, 16'(rdat));
    chk("vectors", 16'hffc0, vector_base_o);
    {rx_clk_i, tx_clk_i, txd_i} <= 3'b100;
    internal_read_i <= 1'b1;
    xfer(1'b1, OFS_BAUD_TEST, 8'h40);
    cyc(2);
    chk("txd pin", 16'h0, 16'(transmit_data_pin_o));
    chk("ext drive", 16'h1, 16'(ext_data_oe_b_o));
    internal_read_i <= 1'b0;
    hit(1, 1);
  endtask

  task automatic t_special;
    boot(1'b1, 1'b0);
    xfer(1'b0, OFS_TEST_CTRL, 8'h00);
    chk("test ctrl", 16'h10, 16'(rdat));
    chk("vectors", 16'hbfc0, vector_base_o);
    chk("wd active", 16'h0, 16'(watchdog_active_o));
    chk("cm active", 16'h0, 16'(clock_monitor_active_o));
    hit(0, 0);
    fw(8'h04, 1, 0);
    fw(8'h08, 0, 1);
    clock_monitor_enable_i <= 1'b0;
    fw(8'h08, 0, 0);
    clock_monitor_enable_i <= 1'b1;
    fw(8'h1c, 0, 0);
    watchdog_disable_config_i <= 1'b1;
    fw(8'h04, 0, 0);
    fw(8'h06, 1, 0);
  endtask

  // override maps memories; condition-code output wins over it
  task automatic t_map;
    xfer(1'b1, OFS_TEST_CTRL, 8'h02);
    cyc(2);
    chk("rom map", 16'h1, 16'(rom_mapped_o));
    chk("wd active", 16'h1, 16'(watchdog_active_o));
    chk("eeprom map", 16'h1, 16'(eeprom_mapped_o));
    chk("cm active", 16'h1, 16'(clock_monitor_active_o));
    cc_flags_i <= 5'h15;
    port_a_normal_i <= 5'h0a;
    xfer(1'b1, OFS_TEST_CTRL, 8'h42);
    cyc(2);
    chk("rom map", 16'h0, 16'(rom_mapped_o));
    chk("port a", 16'h15, 16'(port_a_o));
    xfer(1'b1, OFS_TEST_CTRL, 8'h20);
    cyc(2);
    chk("timer split", 16'h1, 16'(timer_split_o));
    chk("port a", 16'h0a, 16'(port_a_o));
    xfer(1'b0, OFS_TEST_CTRL, 8'h00);
    chk("test ctrl", 16'h20, 16'(rdat));
  endtask

  // baud test bits, visibility, then leaving special mode for good
  task automatic t_baud;
    xfer(1'b1, OFS_BAUD_TEST, 8'hc0);
    watch(4);
    chk("chain reset", 16'h1, 16'(nb));
    xfer(1'b0, OFS_BAUD_TEST, 8'h00);
    chk("baud bits", 16'h0, 16'(rdat));
    for (int i = 0; i < 4; i++)
    begin
      {rx_clk_i, tx_clk_i, txd_i} <= {2'(i), 1'b1};
      cyc(2);
      chk("txd pin", 16'(i[1] ^ i[0]), 16'(transmit_data_pin_o));
    end
    internal_data_i <= 8'ha5;
    internal_read_i <= 1'b1;
    cyc(2);
    chk("ext data", 16'ha5, 16'(ext_data_o));
    chk("ext drive", 16'h0, 16'(ext_data_oe_b_o));
    {rx_clk_i, tx_clk_i, txd_i} <= 3'b100;
    xfer(1'b1, OFS_MODE, 8'h00);
    cyc(2);
    chk("txd pin", 16'h0, 16'(transmit_data_pin_o));
    chk("ext drive", 16'h1, 16'(ext_data_oe_b_o));
    internal_read_i <= 1'b0;
    xfer(1'b1, OFS_TEST_CTRL, 8'h10);
    xfer(1'b0, OFS_TEST_CTRL, 8'h00);
    chk("test ctrl", 16'h0, 16'(rdat));
    xfer(1'b1, OFS_MODE, 8'h0f);
    xfer(1'b0, OFS_MODE, 8'h00);
    chk("mode", 16'h0, 16'(rdat));
  endtask

  task automatic t_addr;
    boot(1'b1, 1'b0);
    cpu_addr_i <= 16'h1234;
    opcode_zero_i <= 1'b1;
    cyc(1);
    opcode_zero_i <= 1'b0;
    chk("counter", 16'h1235, addr_o);
    cyc(3);
    chk("counter", 16'h1238, addr_o);
    boot(1'b1, 1'b0);
    xfer(1'b1, OFS_TEST_CTRL, 8'h90);
    instruction_fetch_indicator_b_i <= 1'b0;
    cyc(5);
    cpu_addr_i <= 16'h2000;
    illegal_opcode_i <= 1'b1;
    cyc(1);
    illegal_opcode_i <= 1'b0;
    chk("illegal addr", 16'h1fff, addr_o);
    chk("no service", 16'h1, 16'(illegal_no_service_o));
    cyc(2);
    chk("illegal addr", 16'h1ffd, addr_o);
    instruction_fetch_indicator_b_i <= 1'b1;
  endtask

  task automatic t_boot;
    boot(1'b1, 1'b1);
    chk("boot rom", 16'h1, 16'(boot_rom_mapped_o));
    chk("vectors", 16'hbfc0, vector_base_o);
    xfer(1'b1, OFS_MODE, 8'h05);
    cyc(2);
    chk("mux bus", 16'h1, 16'(multiplexed_bus_o));
    chk("boot rom", 16'h0, 16'(boot_rom_mapped_o));
  endtask

  // main sequence; every input gets a value at time zero
  initial
  begin
    {hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i, expanded_strap_i} = '0;
    {watchdog_timeout_i, clock_fail_i, illegal_opcode_i, opcode_zero_i} = '0;
    {cc_flags_i, port_a_normal_i, cpu_addr_i, internal_read_i, internal_data_i} = '0;
    {special_mode_strap_i, bootstrap_strap_i, watchdog_disable_config_i} = '0;
    {rx_clk_i, tx_clk_i, txd_i, rom_enable_config_i} = '0;
    {rst_b_i, clock_monitor_enable_i, instruction_fetch_indicator_b_i} = 3'b011;
    hsize_i = 3'h2;
    t_normal();
    t_special();
    t_map();
    t_baud();
    t_addr();
    t_boot();
    final_report();
  end
endmodule

bind special_mode_test_control special_mode_test_control_monitor
  i_special_mode_test_control_monitor (.*);
